// [bench/rcpwm_field_model.sv]
`timescale 1ns/1ps
module rcpwm_field_model (
	input  wire        core_clk,         // Clock
	input  wire [15:0] relayDrive,       // Driver outputs
	input  wire [15:0] extIn,            // External input relays
	output reg  [15:0] relayMonitor = 0  // Sensed states
);
	// Sense path lags the driver, so no same-cycle shortcut
	always @(posedge core_clk) relayMonitor <= relayDrive | extIn;
endmodule

// [bench/rcpwm_props.sv]
`timescale 1ns/1ps
module rcpwm_props #(
	parameter [31:0] TYPE_CODE = 32'h0000a5c3  // Arbitrary type code
) (
	input wire        core_clk,            // Clock
	input wire        sys_rst,             // Reset
	input wire [5:0]  avs_address,         // Address
	input wire        avs_read,            // Read
	input wire        avs_write,           // Write
	input wire [31:0] avs_readdata,        // Read data
	input wire        avs_waitrequest,     // Wait
	input wire        driveStreamFault,    // Stream fault
	input wire [15:0] relayDrive,          // Drive
	input wire        moduleSpecificError  // Type flag
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire rdAns = avs_read && !avs_waitrequest;
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer");
	a_flag_set: assert property (driveStreamFault |-> ##2 moduleSpecificError)
		else $error("flag not set");
	a_flag_cause: assert property ($rose(moduleSpecificError) |-> $past(driveStreamFault, 2))
		else $error("flag without fault");
	a_flag_hold: assert property (moduleSpecificError && !avs_write && !$past(avs_write) |=> moduleSpecificError)
		else $error("flag dropped");
	a_drive_reset: assert property (disable iff (1'b0) sys_rst |=> relayDrive == 16'h0 && avs_waitrequest)
		else $error("reset state");
	a_type_code: assert property (rdAns && avs_address[5:2] == 4'h6 |-> avs_readdata == TYPE_CODE)
		else $error("type code");
	a_vec_width: assert property (rdAns && avs_address[5:2] < 4'h3 |-> avs_readdata[31:16] == 16'h0)
		else $error("vector width");
	cover property (rdAns && avs_address[5:2] == 4'h5);
	cover property ($rose(moduleSpecificError));
	cover property ($fell(relayDrive[0]));
endmodule
bind rcpwm_relay_channel_pwm_driver rcpwm_props #(.TYPE_CODE(TYPE_CODE)) rcpwm_props_inst (
	.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .driveStreamFault, .relayDrive, .moduleSpecificError);

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, flt = 0, lnk = 0, wt, mse;
	logic [5:0] avs_address = 0;
	logic [31:0] wd = 0, rdat, q;
	logic [15:0] relayDrive, mon, extIn = 0, oe, me;
	logic [3:0] be = 4'hf;
	logic [7:0] onE [16], offE [16];
	int err_count = 0, checked = 0, cyc = 0, n;
	initial forever #2.5 core_clk = ~core_clk;
	rcpwm_relay_channel_pwm_driver #(.TICK_CYCLES(32'd10)) rcpwm_relay_channel_pwm_driver_inst (
		.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wt), .relayMonitor(mon), .driveStreamFault(flt),
		.linkErrorEvent(lnk), .relayDrive(relayDrive), .moduleSpecificError(mse));
	rcpwm_field_model rcpwm_field_model_inst (.core_clk(core_clk), .relayDrive(relayDrive),
		.extIn(extIn), .relayMonitor(mon));
	task automatic final_report;
		if (err_count == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			final_report();
		end
	end
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
		@(posedge core_clk);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a;
		wd <= d;
		do @(posedge core_clk); while (wt !== 1'b0);
		q = rdat;
		avs_write <= 0;
		avs_read <= 0;
	endtask
	task automatic rd(logic [5:0] a, logic [31:0] e, string nm);
		bus(0, a, 0);
		chk(nm, q, e);
	endtask
	initial begin
		n = $urandom(32'h5d3c);
		repeat (4) @(posedge core_clk);
		sys_rst <= 0;
		rd(6'h00, 0, "out");
		rd(6'h04, 0, "mode");
		rd(6'h3c, 0, "unmapped");
		bus(1, 6'h18, '1);
		rd(6'h18, 32'h0000a5c3, "typeid");
		for (int i = 0; i < 4; i++) begin
			oe = $urandom;
			me = $urandom;
			bus(1, 6'h00, 32'(oe));
			rd(6'h00, 32'(oe), "out");
			chk("drive", 32'(relayDrive), 32'(oe));
			bus(1, 6'h04, 32'(me));
			rd(6'h04, 32'(me), "mode");
			bus(1, 6'h04, 0);
		end
		be <= 4'h2;
		bus(1, 6'h00, 32'hffff);
		be <= 4'hf;
		rd(6'h00, {16'h0, 8'hff, oe[7:0]}, "lane");
		for (int c = 0; c < 16; c++) begin
			onE[c] = $urandom;
			offE[c] = $urandom;
			bus(1, 6'h10, c);
			bus(1, 6'h14, {offE[c], onE[c]});
		end
		for (int c = 0; c < 16; c++) begin
			bus(1, 6'h10, c);
			rd(6'h14, {16'h0, offE[c], onE[c]}, "period");
		end
		bus(1, 6'h10, 0);
		bus(1, 6'h14, 32'h0302);
		bus(1, 6'h00, 0);
		bus(1, 6'h04, 1);
		repeat (4) @(posedge core_clk);
		while (relayDrive[0] !== 1'b0) @(posedge core_clk);
		for (n = 0; relayDrive[0] !== 1'b1; n++) @(posedge core_clk);
		chk("off", 32'(n), 30);
		for (n = 0; relayDrive[0] !== 1'b0; n++) @(posedge core_clk);
		chk("on", 32'(n), 20);
		bus(1, 6'h14, 32'h0002);
		repeat (12) @(posedge core_clk);
		for (n = 0; n < 60 && relayDrive[0] === 1'b1; n++) @(posedge core_clk);
		chk("offzero", 32'(n), 60);
		bus(1, 6'h04, 0);
		oe = $urandom;
		bus(1, 6'h00, 32'(oe));
		extIn <= $urandom;
		repeat (100) @(posedge core_clk);
		rd(6'h08, 32'(oe | extIn), "phys");
		extIn <= ~extIn | oe;
		me = oe | extIn;
		repeat (20) @(posedge core_clk);
		rd(6'h08, 32'(me), "lag");
		repeat (100) @(posedge core_clk);
		rd(6'h08, 32'(oe | extIn), "phys");
		flt <= 1;
		lnk <= 1;
		@(posedge core_clk);
		flt <= 0;
		lnk <= 0;
		repeat (20) @(posedge core_clk);
		rd(6'h0c, 32'hf, "status");
		chk("mse", 32'(mse), 1);
		bus(1, 6'h0c, 32'h7);
		rd(6'h0c, 0, "status");
		chk("mse", 32'(mse), 0);
		final_report();
	end
endmodule

// [src/rcpwm_map.vh]
`ifndef RCPWM_MAP_VH
`define RCPWM_MAP_VH
// ************************************************************
// Register word offsets (byte address = 4 * index)
// ************************************************************
`define RCPWM_REG_OUTPUTS  4'h0
`define RCPWM_REG_MODES    4'h1
`define RCPWM_REG_PHYS     4'h2
`define RCPWM_REG_STATUS   4'h3
`define RCPWM_REG_CHANSEL  4'h4
`define RCPWM_REG_PERIODS  4'h5
`define RCPWM_REG_TYPEID   4'h6
// ************************************************************
// Field positions
// ************************************************************
`define RCPWM_ST_STREAM    0
`define RCPWM_ST_LINK      1
`define RCPWM_ST_RESET     2
`define RCPWM_ST_MODERR    3
`define RCPWM_PER_ON_LSB   0
`define RCPWM_PER_OFF_LSB  8
// ************************************************************
// Reset values
// ************************************************************
`define RCPWM_RST_OUTPUTS  16'h0000
`define RCPWM_RST_MODES    16'h0000
`define RCPWM_RST_PERIOD   8'h00
// ************************************************************
// Timing
// ************************************************************
`define RCPWM_CLK_HZ       200000000
`define RCPWM_TICK_US      2000
`define RCPWM_TICK_CYC     ((`RCPWM_CLK_HZ / 1000000) * `RCPWM_TICK_US)
`define RCPWM_DEB_MS       10
`define RCPWM_DEB_TICKS    (`RCPWM_DEB_MS / 2)
`define RCPWM_TYPE_CODE    32'h0000a5c3  // Arbitrary type code
`endif

// [src/rcpwm_relay_channel_pwm_driver.v]
`timescale 1ns/1ps
`include "rcpwm_map.vh"

module rcpwm_relay_channel_pwm_driver #(
	parameter [31:0] TICK_CYCLES = `RCPWM_TICK_CYC,   // Core clocks per 2 ms tick
	parameter [31:0] TYPE_CODE   = `RCPWM_TYPE_CODE   // Arbitrary type code
) (
	input  wire        core_clk,                 // 200 MHz clock
	input  wire        sys_rst,                  // Sync reset, high
	input  wire [5:0]  avs_address,              // Byte address
	input  wire        avs_read,                 // Read strobe
	input  wire        avs_write,                // Write strobe
	input  wire [31:0] avs_writedata,            // Write data
	input  wire [3:0]  avs_byteenable,           // Byte enables
	output reg  [31:0] avs_readdata,             // Read data
	output reg         avs_waitrequest,          // Wait request
	input  wire [15:0] relayMonitor,             // Raw physical channel states
	input  wire        driveStreamFault,         // Stream error pulse
	input  wire        linkErrorEvent,           // Link error pulse
	output reg  [15:0] relayDrive,               // Relay driver outputs
	output reg         moduleSpecificError       // Type-specific flag active
);

	// ************************************************************
	// Bus slave
	// ************************************************************
	// One wait cycle: request taken when waitrequest low.
	localparam [0:0] BUS_IDLE   = 1'b0;
	localparam [0:0] BUS_ANSWER = 1'b1;

	wire        busReq    = (avs_read | avs_write);
	wire        accept    = busReq & ~avs_waitrequest;
	wire        wrAcc     = accept & avs_write;
	wire [3:0]  wordIdx   = avs_address[5:2];
	wire        wrOutputs = wrAcc && (wordIdx == `RCPWM_REG_OUTPUTS);
	wire        wrModes   = wrAcc && (wordIdx == `RCPWM_REG_MODES);
	wire        wrStatus  = wrAcc && (wordIdx == `RCPWM_REG_STATUS);
	wire        wrChanSel = wrAcc && (wordIdx == `RCPWM_REG_CHANSEL);
	wire        wrPeriods = wrAcc && (wordIdx == `RCPWM_REG_PERIODS);
	wire [3:0]  statusClr = (wrStatus && avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0;
	reg         busStateReg;
	reg         busStateNext;
	reg         resetSeenReg;
	reg         linkErrReg;
	reg         streamErrReg;
	reg  [15:0] outputsReg;
	reg  [15:0] modesReg;
	reg  [3:0]  chanSelReg;
	reg  [7:0]  onTimeMem  [0:15];
	reg  [7:0]  offTimeMem [0:15];
	reg  [15:0] physReg;
	reg  [31:0] readNext;

	always @* begin
		busStateNext = busStateReg;
		case (busStateReg)
			BUS_IDLE: begin
				if (busReq)
					busStateNext = BUS_ANSWER;
			end
			BUS_ANSWER: begin
				busStateNext = BUS_IDLE;
			end
			default: begin
				busStateNext = BUS_IDLE;
			end
		endcase
	end

	// Waitrequest taken from the next state keeps it a flop output.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			busStateReg     <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			busStateReg     <= busStateNext;
			avs_waitrequest <= (busStateNext != BUS_ANSWER);
		end
	end

	always @* begin
		readNext = 32'h00000000;
		case (wordIdx)
			`RCPWM_REG_OUTPUTS: begin
				readNext[15:0] = outputsReg;
			end
			`RCPWM_REG_MODES: begin
				readNext[15:0] = modesReg;
			end
			`RCPWM_REG_PHYS: begin
				readNext[15:0] = physReg;
			end
			`RCPWM_REG_STATUS: begin
				readNext[`RCPWM_ST_STREAM] = streamErrReg;
				readNext[`RCPWM_ST_LINK]   = linkErrReg;
				readNext[`RCPWM_ST_RESET]  = resetSeenReg;
				readNext[`RCPWM_ST_MODERR] = streamErrReg;
			end
			`RCPWM_REG_CHANSEL: begin
				readNext[3:0] = chanSelReg;
			end
			`RCPWM_REG_PERIODS: begin
				readNext[`RCPWM_PER_ON_LSB+7:`RCPWM_PER_ON_LSB]   = onTimeMem[chanSelReg];
				readNext[`RCPWM_PER_OFF_LSB+7:`RCPWM_PER_OFF_LSB] = offTimeMem[chanSelReg];
			end
			`RCPWM_REG_TYPEID: begin
				readNext = TYPE_CODE;
			end
			default: begin
				readNext = 32'h00000000;
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (sys_rst)
			avs_readdata <= 32'h00000000;
		else if (busReq & avs_waitrequest)
			avs_readdata <= readNext;
	end

	// ************************************************************
	// Control registers
	// ************************************************************
	// Byte lane 0 is channels 0-7, lane 1 channels 8-15.
	always @(posedge core_clk) begin
		if (sys_rst) begin
			outputsReg <= `RCPWM_RST_OUTPUTS;
		end else if (wrOutputs) begin
			if (avs_byteenable[0])
				outputsReg[7:0]  <= avs_writedata[7:0];
			if (avs_byteenable[1])
				outputsReg[15:8] <= avs_writedata[15:8];
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst) begin
			modesReg <= `RCPWM_RST_MODES;
		end else if (wrModes) begin
			if (avs_byteenable[0])
				modesReg[7:0]  <= avs_writedata[7:0];
			if (avs_byteenable[1])
				modesReg[15:8] <= avs_writedata[15:8];
		end
	end

	always @(posedge core_clk) begin
		if (sys_rst)
			chanSelReg <= 4'h0;
		else if (wrChanSel && avs_byteenable[0])
			chanSelReg <= avs_writedata[3:0];
	end

	// Status flags: set wins over clear; writing one clears.
	always @(posedge core_clk) begin
		if (sys_rst)
			streamErrReg <= 1'b0;
		else if (driveStreamFault)
			streamErrReg <= 1'b1;
		else if (statusClr[`RCPWM_ST_STREAM])
			streamErrReg <= 1'b0;
	end

	always @(posedge core_clk) begin
		if (sys_rst)
			linkErrReg <= 1'b0;
		else if (linkErrorEvent)
			linkErrReg <= 1'b1;
		else if (statusClr[`RCPWM_ST_LINK])
			linkErrReg <= 1'b0;
	end

	always @(posedge core_clk) begin
		if (sys_rst)
			resetSeenReg <= 1'b1;
		else if (statusClr[`RCPWM_ST_RESET])
			resetSeenReg <= 1'b0;
	end

	always @(posedge core_clk) begin
		if (sys_rst)
			moduleSpecificError <= 1'b0;
		else
			moduleSpecificError <= streamErrReg;
	end

	// ************************************************************
	// Tick generator, 2 ms
	// ************************************************************
	reg  [31:0] tickCntReg;
	reg         tickReg;
	wire        tickWrap = (tickCntReg == TICK_CYCLES - 32'h00000001);
	always @(posedge core_clk) begin
		if (sys_rst) begin
			tickCntReg <= 32'h00000000;
			tickReg    <= 1'b0;
		end else if (tickWrap) begin
			tickCntReg <= 32'h00000000;
			tickReg    <= 1'b1;
		end else begin
			tickCntReg <= tickCntReg + 32'h00000001;
			tickReg    <= 1'b0;
		end
	end

	// ************************************************************
	// Per-channel period store, PWM and debounce
	// ************************************************************
	genvar ch;
	generate
		for (ch = 0; ch < 16; ch = ch + 1) begin : gChan
			reg       phaseOnReg;
			reg [7:0] phaseCntReg;
			reg [2:0] stableCntReg;
			reg       sampleReg;
			wire      perWr     = wrPeriods && (chanSelReg == ch);
			wire      onDone    = phaseOnReg && (phaseCntReg + 8'h01 >= onTimeMem[ch]);
			wire      offDone   = !phaseOnReg && (phaseCntReg + 8'h01 >= offTimeMem[ch]);
			wire      sameLevel = (relayMonitor[ch] == sampleReg);
			wire      settled   = sameLevel && (stableCntReg + 3'h1 >= `RCPWM_DEB_TICKS);
			wire      pwmLevel;

			always @(posedge core_clk) begin
				if (sys_rst) begin
					onTimeMem[ch]  <= `RCPWM_RST_PERIOD;
					offTimeMem[ch] <= `RCPWM_RST_PERIOD;
				end else if (perWr) begin
					if (avs_byteenable[0])
						onTimeMem[ch] <= avs_writedata[`RCPWM_PER_ON_LSB+7:`RCPWM_PER_ON_LSB];
					if (avs_byteenable[1])
						offTimeMem[ch] <= avs_writedata[`RCPWM_PER_OFF_LSB+7:`RCPWM_PER_OFF_LSB];
				end
			end

			// Zero-length phase still lasts one tick; both zero holds inactive.
			always @(posedge core_clk) begin
				if (sys_rst || !modesReg[ch]) begin
					phaseOnReg  <= 1'b1;
					phaseCntReg <= 8'h00;
				end else if (tickReg) begin
					if (onDone) begin
						phaseOnReg  <= 1'b0;
						phaseCntReg <= 8'h00;
					end else if (offDone) begin
						phaseOnReg  <= 1'b1;
						phaseCntReg <= 8'h00;
					end else
						phaseCntReg <= phaseCntReg + 8'h01;
				end
			end
			// Off count of zero keeps the channel on through the off phase.
			assign pwmLevel = (onTimeMem[ch] != 8'h00) && (phaseOnReg || offTimeMem[ch] == 8'h00);

			always @(posedge core_clk) begin
				if (sys_rst)
					relayDrive[ch] <= 1'b0;
				else
					relayDrive[ch] <= modesReg[ch] ? pwmLevel : outputsReg[ch];
			end

			// New level reported after 5 equal 2 ms samples.
			always @(posedge core_clk) begin
				if (sys_rst)
					sampleReg <= 1'b0;
				else if (tickReg)
					sampleReg <= relayMonitor[ch];
			end

			always @(posedge core_clk) begin
				if (sys_rst)
					stableCntReg <= 3'h0;
				else if (tickReg && !sameLevel)
					stableCntReg <= 3'h1;
				else if (tickReg && stableCntReg < `RCPWM_DEB_TICKS)
					stableCntReg <= stableCntReg + 3'h1;
			end

			always @(posedge core_clk) begin
				if (sys_rst)
					physReg[ch] <= 1'b0;
				else if (tickReg && settled)
					physReg[ch] <= sampleReg;
			end
		end
	endgenerate

endmodule
